/* File: fcr_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Host side of the register port
// ------------------------------------------------------------
module fcr_host (
	input wire logic ref_clk,
	output var logic [7:0] reg_addr,
	output var logic reg_wr,
	output var logic [7:0] reg_wdata,
	output var logic reg_rd,
	input wire logic [7:0] reg_rdata_ff
);
	// Idle lines carry inverted leftovers so a stale value never passes as fresh
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// Data is taken one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata_ff;
	endtask
endmodule
`default_nettype wire

/* File: fcr_pkg.sv */
`default_nettype none
package fcr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] FCR_ADDR_CONFIG = 8'h20;
	localparam logic [7:0] FCR_ADDR_SUMMARY = 8'h24;
	localparam logic [7:0] FCR_ADDR_HALT = 8'h25;
	localparam logic [7:0] FCR_ADDR_STARTUP = 8'h26;
	localparam logic [7:0] FCR_ADDR_UNREACH = 8'h27;
	localparam logic [7:0] FCR_ADDR_ALERT_EN = 8'h29;
	localparam logic [7:0] FCR_ADDR_F2_FLOOR = 8'h48;
	localparam logic [7:0] FCR_ADDR_F2_THRESH = 8'h49;
	localparam logic [7:0] FCR_ADDR_F2_BAND_LO = 8'h4A;
	localparam logic [7:0] FCR_ADDR_F2_BAND_HI = 8'h4B;
	localparam logic [7:0] FCR_ADDR_F2_TGT_LO = 8'h4C;
	localparam logic [7:0] FCR_ADDR_F2_TGT_HI = 8'h4D;
	localparam logic [7:0] FCR_ADDR_F2_MEAS_HI = 8'h4E;
	localparam logic [7:0] FCR_ADDR_F2_MEAS_LO = 8'h4F;
	localparam logic [7:0] FCR_ADDR_LOCK = 8'hEF;
	localparam logic [7:0] FCR_ADDR_PART_ID = 8'hFD;
	localparam logic [7:0] FCR_ADDR_VENDOR_ID = 8'hFE;
	localparam logic [7:0] FCR_ADDR_REVISION = 8'hFF;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] FCR_RST_CONFIG = 8'h40;
	localparam logic [7:0] FCR_RST_ZERO = 8'h00;
	localparam logic [7:0] FCR_RST_F2_FLOOR = 8'h66;
	localparam logic [7:0] FCR_RST_F2_THRESH = 8'hF5;
	localparam logic [7:0] FCR_RST_COUNT_LO = 8'hF8;
	localparam logic [7:0] FCR_RST_COUNT_HI = 8'hFF;
	localparam logic [7:0] FCR_UNMAPPED_DATA = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FCR_CFG_ALERT_BLOCK = 7;
	localparam int FCR_CFG_TIMEOUT_DIS = 6;
	localparam int FCR_CFG_CONT_TIMER = 5;
	localparam int FCR_CFG_CLK_OE = 1;
	localparam int FCR_CFG_CLK_SRC = 0;
	localparam int FCR_SUM_WATCH = 7;
	localparam int FCR_SUM_UNREACH = 2;
	localparam int FCR_SUM_STARTUP = 1;
	localparam int FCR_SUM_HALT = 0;
	localparam int FCR_LOCK_BIT = 0;
	localparam logic [7:0] FCR_CFG_WMASK = 8'hE3;
	localparam int FCR_CHANNELS = 2;

	// Per-channel fault indications from the speed control logic
	typedef struct packed {
		logic [FCR_CHANNELS-1:0] rotor_halt;
		logic [FCR_CHANNELS-1:0] startup_failure;
		logic [FCR_CHANNELS-1:0] speed_unreachable;
	} fcr_fault_type;

	// Fan 2 programming handed to the speed control logic
	typedef struct packed {
		logic [7:0] drive_floor;
		logic [7:0] spinning_threshold;
		logic [15:0] fail_band;
		logic [15:0] target_count;
	} fcr_fan2_cfg_type;

endpackage
`default_nettype wire

/* File: fcr_regs.sv */
`timescale 1ns/1ns
`default_nettype none

// Operation
// RL1: Reads of undefined addresses return 00h.
// RL2: Writes to undefined addresses are dropped without any effect.
// RL3: Reset loads every register with its listed default.
// RL4: Once lock bit sets, lockable registers including lock itself ignore writes.
// RL5: Global configuration register is lockable.
// RL6: Alert block bit set keeps alert output deasserted always.
// RL7: With block clear, any set status bit asserts alert unless channel-masked.
// RL8: Config bit 6 disables bus timeout; default one disables it.
// RL9: Config bit 5 selects continuous watchdog; default zero is power-up only.
// RL10: Config bit 1 drives internal tach clock out on clock pin.
// RL11: Config bit 0 selects clock pin as tachometer timing source.
// RL12: Clock output set forces internal oscillator regardless of source select.
// RL13: Watchdog expiry sets status bit 7 and forces full duty until reprogrammed.
// RL14: Reading summary status clears the watchdog-expired bit.
// RL15: Summary bit 2 is OR of per-fan drive-fail flags.
// RL16: Summary bit 1 is OR of per-fan spin-up failure flags.
// RL17: Summary bit 0 is OR of per-fan stall flags.
// RL18: Stall flag sets on stall; read clears it only after stall ends.
// RL19: Spin-up flag sets on failure; read clears it only once gone.
// RL20: Drive-fail flag sets on failure; read clears it only once gone.
// RL21: Fan 2 tach reading bytes are read-only, reset FFh and F8h.
// RL22: Channel alert enable gates that channel's errors onto alert; flags still update.
// RL23: Alert is active low, released when no enabled unmasked flag remains.
module fcr_regs
	import fcr_pkg::*;
#(
	parameter int FAN_CHANNELS = FCR_CHANNELS,
	parameter logic [7:0] PART_ID = 8'hA1,    // Arbitrary value
	parameter logic [7:0] VENDOR_ID = 8'h2C,  // Arbitrary value
	parameter logic [7:0] REVISION_ID = 8'h01 // Arbitrary value
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_ff,
	input wire fcr_fault_type fault_det,
	input wire logic watchdog_expired,
	input wire logic fans_reprogrammed,
	input wire logic [15:0] fan2_measured_count,
	output logic alert_n_ff,
	output logic bus_timeout_disable_ff,
	output logic continuous_timer_enable_ff,
	output logic clock_pin_output_enable_ff,
	output logic tach_clk_from_pin_ff,
	output logic full_drive_ff,
	output fcr_fan2_cfg_type fan2_cfg_ff
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	// The map has room for exactly two channels in each flag register
	if (FAN_CHANNELS != FCR_CHANNELS) begin : g_bad_channels
		$error("fcr_regs supports two fan channels only");
	end

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] config_ff;
	logic [7:0] nxt_config;
	logic [1:0] alert_en_ff;
	logic lock_ff;
	logic watch_ff;
	logic nxt_watch;
	logic [1:0] halt_ff;
	logic [1:0] nxt_halt;
	logic [1:0] startup_ff;
	logic [1:0] nxt_startup;
	logic [1:0] unreach_ff;
	logic [1:0] nxt_unreach;
	logic [15:0] meas_ff;
	logic [7:0] nxt_rdata;
	logic [7:0] summary;
	logic [1:0] chan_err;
	logic alert_cond;
	logic cfg_wr;
	logic lockable_ok;

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	// Lockable writes pass only while the lock is still open
	assign lockable_ok = reg_wr && !lock_ff; // [RL4]
	assign cfg_wr = lockable_ok && (reg_addr == FCR_ADDR_CONFIG); // [RL5]

	// ----------------------------------------------------------------
	// Global configuration
	// ----------------------------------------------------------------
	// Only the defined bits are stored; the rest read as zero
	always_comb begin
		nxt_config = config_ff;
		if (cfg_wr) begin
			nxt_config = reg_wdata & FCR_CFG_WMASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			config_ff <= FCR_RST_CONFIG; // [RL3]
		end else begin
			config_ff <= nxt_config;
		end
	end

	// Control outputs take the next value, so they change on the same edge as the stored bits
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bus_timeout_disable_ff <= FCR_RST_CONFIG[FCR_CFG_TIMEOUT_DIS];
			continuous_timer_enable_ff <= FCR_RST_CONFIG[FCR_CFG_CONT_TIMER];
			clock_pin_output_enable_ff <= FCR_RST_CONFIG[FCR_CFG_CLK_OE];
			tach_clk_from_pin_ff <= 1'b0;
		end else begin
			bus_timeout_disable_ff <= nxt_config[FCR_CFG_TIMEOUT_DIS]; // [RL8]
			continuous_timer_enable_ff <= nxt_config[FCR_CFG_CONT_TIMER]; // [RL9]
			clock_pin_output_enable_ff <= nxt_config[FCR_CFG_CLK_OE]; // [RL10]
			// A pin that we drive cannot also be our timing source
			tach_clk_from_pin_ff <= nxt_config[FCR_CFG_CLK_SRC] // [RL11]
				&& !nxt_config[FCR_CFG_CLK_OE]; // [RL12]
		end
	end

	// ----------------------------------------------------------------
	// Channel alert enable, not lockable
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			alert_en_ff <= FCR_RST_ZERO[1:0];
		end else if (reg_wr && (reg_addr == FCR_ADDR_ALERT_EN)) begin
			alert_en_ff <= reg_wdata[1:0]; // [RL22]
		end
	end

	// ----------------------------------------------------------------
	// Software lock
	// ----------------------------------------------------------------
	// Sticky until reset: the lock register is itself locked once set
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lock_ff <= FCR_RST_ZERO[FCR_LOCK_BIT];
		end else if (lockable_ok && (reg_addr == FCR_ADDR_LOCK)) begin
			lock_ff <= reg_wdata[FCR_LOCK_BIT]; // [RL4]
		end
	end

	// ----------------------------------------------------------------
	// Fan 2 programming, all lockable except the target count
	// ----------------------------------------------------------------
	// One process owns the whole struct so it has a single driver; the
	// target count stays writable under lock so speed can still be set
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fan2_cfg_ff.drive_floor <= FCR_RST_F2_FLOOR; // [RL3]
			fan2_cfg_ff.spinning_threshold <= FCR_RST_F2_THRESH;
			fan2_cfg_ff.fail_band <= {FCR_RST_ZERO, FCR_RST_ZERO};
			fan2_cfg_ff.target_count <= {FCR_RST_COUNT_HI, FCR_RST_COUNT_LO};
		end else if (reg_wr) begin
			case (reg_addr)
				FCR_ADDR_F2_FLOOR: begin
					if (lockable_ok) begin // [RL4]
						fan2_cfg_ff.drive_floor <= reg_wdata;
					end
				end
				FCR_ADDR_F2_THRESH: begin
					if (lockable_ok) begin // [RL4]
						fan2_cfg_ff.spinning_threshold <= reg_wdata;
					end
				end
				FCR_ADDR_F2_BAND_LO: begin
					if (lockable_ok) begin // [RL4]
						fan2_cfg_ff.fail_band[7:0] <= reg_wdata;
					end
				end
				FCR_ADDR_F2_BAND_HI: begin
					if (lockable_ok) begin // [RL4]
						fan2_cfg_ff.fail_band[15:8] <= reg_wdata;
					end
				end
				FCR_ADDR_F2_TGT_LO: begin
					fan2_cfg_ff.target_count[7:0] <= reg_wdata;
				end
				FCR_ADDR_F2_TGT_HI: begin
					fan2_cfg_ff.target_count[15:8] <= reg_wdata;
				end
				default: begin // [RL2]
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Fan 2 measured count
	// ----------------------------------------------------------------
	// Read-only; writes to these offsets decode to nothing
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meas_ff <= {FCR_RST_COUNT_HI, FCR_RST_COUNT_LO}; // [RL21]
		end else begin
			meas_ff <= fan2_measured_count;
		end
	end

	// ----------------------------------------------------------------
	// Sticky fault flags
	// ----------------------------------------------------------------
	// A live condition both sets the flag and blocks the read clear, so
	// an event coinciding with the read is never lost
	always_comb begin
		nxt_halt = halt_ff | fault_det.rotor_halt; // [RL18]
		nxt_startup = startup_ff | fault_det.startup_failure; // [RL19]
		nxt_unreach = unreach_ff | fault_det.speed_unreachable; // [RL20]
		if (reg_rd && (reg_addr == FCR_ADDR_HALT)) begin
			nxt_halt = fault_det.rotor_halt; // [RL18]
		end
		if (reg_rd && (reg_addr == FCR_ADDR_STARTUP)) begin
			nxt_startup = fault_det.startup_failure; // [RL19]
		end
		if (reg_rd && (reg_addr == FCR_ADDR_UNREACH)) begin
			nxt_unreach = fault_det.speed_unreachable; // [RL20]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			halt_ff <= FCR_RST_ZERO[1:0]; // [RL3]
			startup_ff <= FCR_RST_ZERO[1:0];
			unreach_ff <= FCR_RST_ZERO[1:0];
		end else begin
			halt_ff <= nxt_halt;
			startup_ff <= nxt_startup;
			unreach_ff <= nxt_unreach;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog expiry
	// ----------------------------------------------------------------
	// Expiry wins over a summary read in the same cycle
	always_comb begin
		nxt_watch = watch_ff;
		if (reg_rd && (reg_addr == FCR_ADDR_SUMMARY)) begin
			nxt_watch = 1'b0; // [RL14]
		end
		if (watchdog_expired) begin
			nxt_watch = 1'b1; // [RL13]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			watch_ff <= 1'b0;
		end else begin
			watch_ff <= nxt_watch;
		end
	end

	// Full duty holds until the fans are reprogrammed, not until the read
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			full_drive_ff <= 1'b0;
		end else if (watchdog_expired) begin
			full_drive_ff <= 1'b1; // [RL13]
		end else if (fans_reprogrammed) begin
			full_drive_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Summary status
	// ----------------------------------------------------------------
	// Summary bits 2 to 0 are views of the per-fan flags and bit 7 of watch_ff, never stored twice
	always_comb begin
		summary = FCR_RST_ZERO;
		summary[FCR_SUM_WATCH] = watch_ff;
		summary[FCR_SUM_UNREACH] = |unreach_ff; // [RL15]
		summary[FCR_SUM_STARTUP] = |startup_ff; // [RL16]
		summary[FCR_SUM_HALT] = |halt_ff; // [RL17]
	end

	// ----------------------------------------------------------------
	// Alert
	// ----------------------------------------------------------------
	// Built from next-state flags so alert moves with the flags it shows
	always_comb begin
		chan_err = (nxt_halt | nxt_startup | nxt_unreach) & alert_en_ff; // [RL22]
		alert_cond = (|chan_err) || nxt_watch; // [RL7]
		if (nxt_config[FCR_CFG_ALERT_BLOCK]) begin
			alert_cond = 1'b0; // [RL6]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			alert_n_ff <= 1'b1;
		end else begin
			alert_n_ff <= !alert_cond; // [RL23]
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rdata = FCR_UNMAPPED_DATA; // [RL1]
		case (reg_addr)
			FCR_ADDR_CONFIG: begin
				nxt_rdata = config_ff;
			end
			FCR_ADDR_SUMMARY: begin
				nxt_rdata = summary;
			end
			FCR_ADDR_HALT: begin
				nxt_rdata = {6'h00, halt_ff};
			end
			FCR_ADDR_STARTUP: begin
				nxt_rdata = {6'h00, startup_ff};
			end
			FCR_ADDR_UNREACH: begin
				nxt_rdata = {6'h00, unreach_ff};
			end
			FCR_ADDR_ALERT_EN: begin
				nxt_rdata = {6'h00, alert_en_ff};
			end
			FCR_ADDR_F2_FLOOR: begin
				nxt_rdata = fan2_cfg_ff.drive_floor;
			end
			FCR_ADDR_F2_THRESH: begin
				nxt_rdata = fan2_cfg_ff.spinning_threshold;
			end
			FCR_ADDR_F2_BAND_LO: begin
				nxt_rdata = fan2_cfg_ff.fail_band[7:0];
			end
			FCR_ADDR_F2_BAND_HI: begin
				nxt_rdata = fan2_cfg_ff.fail_band[15:8];
			end
			FCR_ADDR_F2_TGT_LO: begin
				nxt_rdata = fan2_cfg_ff.target_count[7:0];
			end
			FCR_ADDR_F2_TGT_HI: begin
				nxt_rdata = fan2_cfg_ff.target_count[15:8];
			end
			FCR_ADDR_F2_MEAS_HI: begin
				nxt_rdata = meas_ff[15:8]; // [RL21]
			end
			FCR_ADDR_F2_MEAS_LO: begin
				nxt_rdata = meas_ff[7:0]; // [RL21]
			end
			FCR_ADDR_LOCK: begin
				nxt_rdata = {7'h00, lock_ff};
			end
			FCR_ADDR_PART_ID: begin
				nxt_rdata = PART_ID;
			end
			FCR_ADDR_VENDOR_ID: begin
				nxt_rdata = VENDOR_ID;
			end
			FCR_ADDR_REVISION: begin
				nxt_rdata = REVISION_ID;
			end
			default: begin
				nxt_rdata = FCR_UNMAPPED_DATA; // [RL1]
			end
		endcase
	end

	// Data is captured on the read strobe and held until the next one
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata_ff <= FCR_RST_ZERO;
		end else if (reg_rd) begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// Writes to offsets with no case above fall through untouched [RL2]

endmodule
`default_nettype wire

/* File: fcr_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module fcr_regs_bench
	import fcr_pkg::*;
;
	logic ref_clk, rst_n, reg_wr, reg_rd, watchdog_expired, fans_reprogrammed;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
	logic [15:0] meas;
	logic alert_n_ff, bus_timeout_disable_ff, continuous_timer_enable_ff;
	logic clock_pin_output_enable_ff, tach_clk_from_pin_ff, full_drive_ff;
	fcr_fault_type fault;
	fcr_fan2_cfg_type fan2_cfg_ff;
	int err_count = 0;
	int comparisons = 0;
	logic [7:0] ra [14] = '{8'h20, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h48, 8'h49, 8'h4A,
		8'h4B, 8'h4C, 8'h4D, 8'hEF, 8'h21};
	logic [7:0] rv [14] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h66, 8'hF5, 8'h00,
		8'h00, 8'hF8, 8'hFF, 8'h00, 8'h00};
	fcr_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .fault_det(fault),
		.watchdog_expired(watchdog_expired), .fans_reprogrammed(fans_reprogrammed),
		.fan2_measured_count(meas), .alert_n_ff(alert_n_ff),
		.bus_timeout_disable_ff(bus_timeout_disable_ff),
		.continuous_timer_enable_ff(continuous_timer_enable_ff),
		.clock_pin_output_enable_ff(clock_pin_output_enable_ff),
		.tach_clk_from_pin_ff(tach_clk_from_pin_ff), .full_drive_ff(full_drive_ff),
		.fan2_cfg_ff(fan2_cfg_ff));
	fcr_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));
	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	always #4 ref_clk = ~ref_clk;
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk($sformatf("register %h", a), exp, d);
	endtask
	// Holds one fault pattern for a single cycle, then clears it
	task automatic blip(input fcr_fault_type f);
		@(negedge ref_clk);
		fault = f;
		@(negedge ref_clk);
		fault = '0;
	endtask
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 14; i++) begin
			rdc(ra[i], rv[i]);
		end
		$display("reset values done");
	endtask
	task automatic t_config();
		host.wr(8'h20, 8'hE3);
		chk("cfg pins", 8'h0E, {4'h0, bus_timeout_disable_ff, continuous_timer_enable_ff,
			clock_pin_output_enable_ff, tach_clk_from_pin_ff});
		rdc(8'h20, 8'hE3);
		host.wr(8'h20, 8'h01);
		chk("cfg pins", 8'h01, {4'h0, bus_timeout_disable_ff, continuous_timer_enable_ff,
			clock_pin_output_enable_ff, tach_clk_from_pin_ff});
		host.wr(8'h4C, 8'h12);
		host.wr(8'h48, 8'h5A);
		chk("target lo", 8'h12, fan2_cfg_ff.target_count[7:0]);
		chk("floor", 8'h5A, fan2_cfg_ff.drive_floor);
		host.wr(8'h21, 8'hFF);
		rdc(8'h21, 8'h00);
		host.wr(8'h4E, 8'h00);
		rdc(8'h4E, 8'hFF);
		rdc(8'h4F, 8'hF8);
		meas = 16'h1234;
		host.wr(8'h4F, 8'h00);
		rdc(8'h4E, 8'h12);
		rdc(8'h4F, 8'h34);
		$display("config done");
	endtask
	task automatic t_faults();
		host.wr(8'h29, 8'h03);
		host.wr(8'h20, 8'h00);
		blip('{rotor_halt: 2'b01, default: '0});
		chk("alert_n", 8'h00, {7'h0, alert_n_ff});
		rdc(8'h24, 8'h01);
		rdc(8'h25, 8'h01);
		rdc(8'h25, 8'h00);
		chk("alert_n", 8'h01, {7'h0, alert_n_ff});
		fault.startup_failure = 2'b10;
		rdc(8'h26, 8'h02);
		rdc(8'h24, 8'h02);
		fault.startup_failure = 2'b00;
		rdc(8'h26, 8'h02);
		rdc(8'h26, 8'h00);
		host.wr(8'h29, 8'h02);
		blip('{speed_unreachable: 2'b01, default: '0});
		chk("alert_n", 8'h01, {7'h0, alert_n_ff});
		rdc(8'h24, 8'h04);
		rdc(8'h27, 8'h01);
		rdc(8'h27, 8'h00);
		host.wr(8'h29, 8'h03);
		host.wr(8'h20, 8'h80);
		blip('{rotor_halt: 2'b10, default: '0});
		chk("alert_n", 8'h01, {7'h0, alert_n_ff});
		rdc(8'h25, 8'h02);
		$display("fault flags done");
	endtask
	task automatic t_watch();
		host.wr(8'h20, 8'h00);
		@(negedge ref_clk);
		watchdog_expired = 1'b1;
		@(negedge ref_clk);
		watchdog_expired = 1'b0;
		chk("full drive", 8'h01, {7'h0, full_drive_ff});
		chk("alert_n", 8'h00, {7'h0, alert_n_ff});
		rdc(8'h24, 8'h80);
		rdc(8'h24, 8'h00);
		chk("full drive", 8'h01, {7'h0, full_drive_ff});
		@(negedge ref_clk);
		fans_reprogrammed = 1'b1;
		@(negedge ref_clk);
		fans_reprogrammed = 1'b0;
		chk("full drive", 8'h00, {7'h0, full_drive_ff});
		$display("watchdog done");
	endtask
	task automatic t_lock();
		host.wr(8'h20, 8'h01);
		host.wr(8'hEF, 8'h01);
		host.wr(8'h20, 8'hE2);
		rdc(8'h20, 8'h01);
		host.wr(8'h48, 8'h11);
		rdc(8'h48, 8'h5A);
		host.wr(8'hEF, 8'h00);
		rdc(8'hEF, 8'h01);
		host.wr(8'h4C, 8'h77);
		rdc(8'h4C, 8'h77);
		$display("lock done");
	endtask
	// Reset in mid-run must undo the lock and the programmed config, floor and target low values
	task automatic t_reset_again();
		@(negedge ref_clk);
		rst_n = 1'b0;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		rdc(8'hEF, 8'h00);
		rdc(8'h48, 8'h66);
		rdc(8'h4C, 8'hF8);
		rdc(8'h20, 8'h40);
		chk("alert_n", 8'h01, {7'h0, alert_n_ff});
		chk("full drive", 8'h00, {7'h0, full_drive_ff});
		$display("second reset done");
	endtask
	// Bound well beyond the roughly 140 cycles the scenarios need
	initial begin
		#40000;
		err_count++;
		wrap_up();
	end
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		fault = '0;
		watchdog_expired = 1'b0;
		fans_reprogrammed = 1'b0;
		meas = 16'hFFF8;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		t_reset();
		t_config();
		t_faults();
		t_watch();
		t_lock();
		t_reset_again();
		wrap_up();
	end
endmodule
`default_nettype wire

/* File: fcr_regs_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Port checker for the register bank
// ------------------------------------------------------------
module fcr_regs_props
	import fcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_ff,
	input wire fcr_fault_type fault_det,
	input wire logic watchdog_expired,
	input wire logic fans_reprogrammed,
	input wire logic alert_n_ff,
	input wire logic bus_timeout_disable_ff,
	input wire logic continuous_timer_enable_ff,
	input wire logic clock_pin_output_enable_ff,
	input wire logic tach_clk_from_pin_ff,
	input wire logic full_drive_ff
);
	logic lock_ff;
	logic block_ff;
	logic mapped;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Lock shadow: once set it holds until reset, so later writes cannot clear it
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lock_ff <= 1'b0;
		end else if (reg_wr && reg_addr == FCR_ADDR_LOCK && reg_wdata[0]) begin
			lock_ff <= 1'b1;
		end
	end
	// Alert block shadow, follows accepted configuration writes
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			block_ff <= 1'b0;
		end else if (reg_wr && reg_addr == FCR_ADDR_CONFIG && !lock_ff) begin
			block_ff <= reg_wdata[7];
		end
	end
	// Decoded offsets
	always_comb begin
		mapped = reg_addr inside {8'h20, [8'h24:8'h27], 8'h29, [8'h48:8'h4F], 8'hEF,
			[8'hFD:8'hFF]};
	end
	sequence cfg_take;
		reg_wr && reg_addr == FCR_ADDR_CONFIG && !lock_ff;
	endsequence
	sequence cfg_blocked;
		reg_wr && reg_addr == FCR_ADDR_CONFIG && lock_ff;
	endsequence
	unmapped_read_a: assert property (reg_rd && !mapped |=> reg_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	config_stable_a: assert property (!(reg_wr && reg_addr == FCR_ADDR_CONFIG) |=>
		$stable(bus_timeout_disable_ff) && $stable(continuous_timer_enable_ff)
		&& $stable(clock_pin_output_enable_ff)) else $error("config moved without write");
	cfg_write_a: assert property (cfg_take |=> bus_timeout_disable_ff == $past(reg_wdata[6])
		&& continuous_timer_enable_ff == $past(reg_wdata[5])
		&& clock_pin_output_enable_ff == $past(reg_wdata[1]))
		else $error("config write not applied");
	cfg_locked_a: assert property (cfg_blocked |=> $stable(bus_timeout_disable_ff)
		&& $stable(tach_clk_from_pin_ff)) else $error("locked config changed");
	tach_src_a: assert property (cfg_take |=>
		tach_clk_from_pin_ff == ($past(reg_wdata[0]) && !$past(reg_wdata[1])))
		else $error("tach clock source wrong");
	alert_block_a: assert property (block_ff |-> alert_n_ff)
		else $error("alert while blocked");
	alert_raise_a: assert property (!block_ff && !reg_wr && watchdog_expired |=> !alert_n_ff)
		else $error("alert not raised");
	full_drive_a: assert property (watchdog_expired |=> full_drive_ff)
		else $error("full drive not set");
	full_hold_a: assert property (full_drive_ff && !fans_reprogrammed |=> full_drive_ff)
		else $error("full drive dropped");
	halt_capture_a: assert property (reg_rd && reg_addr == FCR_ADDR_HALT && $past(rst_n) |=>
		(reg_rdata_ff[1:0] & $past(fault_det.rotor_halt, 2)) == $past(fault_det.rotor_halt, 2))
		else $error("halt flag missed");
endmodule
bind fcr_regs fcr_regs_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
	.fault_det(fault_det), .watchdog_expired(watchdog_expired),
	.fans_reprogrammed(fans_reprogrammed), .alert_n_ff(alert_n_ff),
	.bus_timeout_disable_ff(bus_timeout_disable_ff),
	.continuous_timer_enable_ff(continuous_timer_enable_ff),
	.clock_pin_output_enable_ff(clock_pin_output_enable_ff),
	.tach_clk_from_pin_ff(tach_clk_from_pin_ff), .full_drive_ff(full_drive_ff));
`default_nettype wire
